/* hdl/exec_pkg.sv */
// Package of encodings, field positions and flag layout for the add/and executor
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 12;
    // Opcode fields
    localparam logic [7:0] OP_ADD_LITERAL = 8'h0F;
    localparam logic [7:0] OP_AND_LITERAL = 8'h0B;
    localparam logic [5:0] OP_ADD_ACC_TO_REG = 6'h09;
    localparam logic [5:0] OP_ADD_WITH_CARRY = 6'h08;
    localparam int OP8_HI = 15;
    localparam int OP8_LO = 8;
    localparam int OP6_LO = 10;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    localparam int BANK_W = 4;
    // Quick-access bank: offsets below 60h in bank 0, offsets from 60h up in the top bank
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    // Status flag positions
    localparam int FLAG_W = 5;
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } phase_e;
endpackage

/* hdl/add_unit.sv */
// Eight-bit adder with carry in producing result and arithmetic flags
`timescale 1ns/1ns
`default_nettype none
module add_unit (
    input wire logic [exec_pkg::DATA_W-1:0] i_a,
    input wire logic [exec_pkg::DATA_W-1:0] i_b,
    input wire logic i_cin,
    output logic [exec_pkg::DATA_W-1:0] o_sum,
    output logic o_carry,
    output logic o_digit_carry,
    output logic o_overflow
);
    import exec_pkg::*;
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    assign low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
    assign full_sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
    assign o_sum = full_sum[7:0];
    assign o_carry = full_sum[8];
    assign o_digit_carry = low_sum[4];
    // Signed overflow: like-signed operands giving an opposite-signed sum
    assign o_overflow = (i_a[7] == i_b[7]) && (full_sum[7] != i_a[7]);
endmodule
`default_nettype wire

/* hdl/add_and_instruction_exec.sv */
// Four-phase executor for add-literal, add-to-register, add-with-carry, and-literal
`timescale 1ns/1ns
`default_nettype none
module add_and_instruction_exec #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 12
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [exec_pkg::WORD_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic i_extended_en,
    input wire logic [exec_pkg::BANK_W-1:0] i_bank_select_register,
    input wire logic [ADDR_W-1:0] i_index_base,
    input wire logic [DATA_W-1:0] i_rd_data,
    output logic o_busy,
    output logic [1:0] o_phase,
    output logic o_rd_en,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_wr_en,
    output logic [DATA_W-1:0] o_wr_data,
    output logic [DATA_W-1:0] o_acc,
    output logic o_negative_flag,
    output logic o_overflow_flag,
    output logic o_zero_flag,
    output logic o_digit_carry_flag,
    output logic o_carry_flag,
    output logic o_illegal,
    output logic o_done
);
    import exec_pkg::*;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    phase_e phase;
    phase_e next_phase;
    logic [WORD_W-1:0] instr;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic [FLAG_W-1:0] new_flags;
    logic [DATA_W-1:0] acc;
    logic [FLAG_W-1:0] status;

    wire in_start = (phase == PH_DECODE) && i_instr_valid;
    // Incoming word while taken, so the address and read strobe leave together
    wire [WORD_W-1:0] dec_instr = in_start ? i_instr : instr;
    wire is_add_literal = dec_instr[OP8_HI:OP8_LO] == OP_ADD_LITERAL;
    wire is_and_literal = dec_instr[OP8_HI:OP8_LO] == OP_AND_LITERAL;
    wire is_add_reg = dec_instr[OP8_HI:OP6_LO] == OP_ADD_ACC_TO_REG;
    wire is_add_carry = dec_instr[OP8_HI:OP6_LO] == OP_ADD_WITH_CARRY;
    wire is_reg_op = is_add_reg || is_add_carry;
    wire is_add = is_add_literal || is_add_reg || is_add_carry;
    wire is_known = is_add || is_and_literal;
    wire dest_reg = dec_instr[DEST_BIT];
    wire bank_sel = dec_instr[BANK_BIT];
    wire [7:0] faddr = dec_instr[7:0];
    wire new_known = (i_instr[OP8_HI:OP8_LO] == OP_ADD_LITERAL)
        || (i_instr[OP8_HI:OP8_LO] == OP_AND_LITERAL)
        || (i_instr[OP8_HI:OP6_LO] == OP_ADD_ACC_TO_REG)
        || (i_instr[OP8_HI:OP6_LO] == OP_ADD_WITH_CARRY);

    // ----------------------------------------
    // Address formation
    // ----------------------------------------
    wire use_indexed = !bank_sel && i_extended_en && (faddr <= INDEX_LIMIT);
    wire [ADDR_W-1:0] indexed_addr = i_index_base + {{(ADDR_W-8){1'b0}}, faddr};
    wire [ADDR_W-1:0] access_addr = (faddr >= ACCESS_SPLIT) ?
        {ACCESS_HI_BANK, faddr} : {{(ADDR_W-8){1'b0}}, faddr};
    wire [ADDR_W-1:0] banked_addr = {i_bank_select_register, faddr};
    wire [ADDR_W-1:0] eff_addr = use_indexed ? indexed_addr :
        (bank_sel ? banked_addr : access_addr);

    // ----------------------------------------
    // Data path
    // ----------------------------------------
    logic [DATA_W-1:0] sum;
    logic add_c;
    logic add_dc;
    logic add_ov;
    wire [DATA_W-1:0] add_b = is_reg_op ? operand : faddr;
    wire add_cin = is_add_carry && status[FLG_C];

    add_unit u_add (
        .i_a(acc),
        .i_b(add_b),
        .i_cin(add_cin),
        .o_sum(sum),
        .o_carry(add_c),
        .o_digit_carry(add_dc),
        .o_overflow(add_ov)
    );

    wire [DATA_W-1:0] and_res = acc & faddr;
    wire [DATA_W-1:0] next_result = is_and_literal ? and_res : sum;
    wire res_z = next_result == '0;
    // Logic ops keep the arithmetic flags as they were
    wire [FLAG_W-1:0] next_flags = is_add ?
        {next_result[7], add_ov, res_z, add_dc, add_c} :
        {next_result[7], status[FLG_OV], res_z, status[FLG_DC], status[FLG_C]};
    wire to_reg = is_reg_op && dest_reg;

    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    always_comb begin
        case (phase)
            PH_DECODE: next_phase = (i_instr_valid && new_known) ? PH_READ : PH_DECODE;
            PH_READ: next_phase = PH_PROCESS;
            PH_PROCESS: next_phase = PH_WRITE;
            PH_WRITE: next_phase = PH_DECODE;
            default: next_phase = PH_DECODE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            phase <= PH_DECODE;
            instr <= '0;
            operand <= '0;
            result <= '0;
            new_flags <= STATUS_RESET;
            acc <= ACC_RESET;
            status <= STATUS_RESET;
        end else begin
            phase <= next_phase;
            if (in_start) begin
                instr <= i_instr;
            end
            if (phase == PH_READ) begin
                operand <= i_rd_data;
            end
            if (phase == PH_PROCESS) begin
                result <= next_result;
                new_flags <= next_flags;
            end
            if (phase == PH_WRITE) begin
                status <= new_flags;
                if (!to_reg) begin
                    acc <= result;
                end
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_busy <= 1'b0;
            o_phase <= PH_DECODE;
            o_rd_en <= 1'b0;
            o_addr <= '0;
            o_wr_en <= 1'b0;
            o_wr_data <= '0;
            o_illegal <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_busy <= next_phase != PH_DECODE;
            o_phase <= next_phase;
            // Read strobe is issued so data is present during the read phase
            o_rd_en <= in_start && new_known && is_reg_op;
            o_addr <= (in_start && new_known) ? eff_addr : o_addr;
            o_wr_en <= (phase == PH_PROCESS) && to_reg;
            o_wr_data <= (phase == PH_PROCESS) ? next_result : o_wr_data;
            o_illegal <= in_start && !new_known;
            o_done <= phase == PH_WRITE;
        end
    end

    assign o_acc = acc;
    assign o_negative_flag = status[FLG_N];
    assign o_overflow_flag = status[FLG_OV];
    assign o_zero_flag = status[FLG_Z];
    assign o_digit_carry_flag = status[FLG_DC];
    assign o_carry_flag = status[FLG_C];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_cycle_four_phase: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_READ) |=> (phase == PH_PROCESS) ##1 (phase == PH_WRITE)
        ##1 (phase == PH_DECODE))
        else $error("phase sequence broken");
    a_add_literal_acc: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_PROCESS && is_add_literal) |=> ##1 (acc == $past(acc + faddr, 2)))
        else $error("add literal result wrong");
    a_and_literal_acc: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_PROCESS && is_and_literal) |=> ##1 (acc == $past(and_res, 2)))
        else $error("and literal result wrong");
    a_and_keeps_flags: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_WRITE && is_and_literal) |=> (status[FLG_C] == $past(status[FLG_C])
        && status[FLG_OV] == $past(status[FLG_OV]) && status[FLG_DC] == $past(status[FLG_DC])))
        else $error("and literal touched arithmetic flags");
    a_dest_reg_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_PROCESS && to_reg) |=> o_wr_en ##1 $stable(acc))
        else $error("register destination misrouted");
    a_dest_acc_nowrite: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_PROCESS && is_reg_op && !dest_reg) |=> !o_wr_en)
        else $error("accumulator destination wrote register");
    a_indexed_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (in_start && new_known && use_indexed) |=> (o_addr == $past(indexed_addr)))
        else $error("indexed address wrong");
    a_bank_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (in_start && new_known && bank_sel)
        |=> (o_addr[ADDR_W-1:8] == $past(i_bank_select_register)))
        else $error("bank select not applied");
    a_zero_flag_add: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_PROCESS && is_add) |=> ##1 (status[FLG_Z] == (o_wr_data == '0)))
        else $error("zero flag wrong");
    a_carry_in_used: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (phase == PH_PROCESS && is_add_carry) |=> (result == $past(acc + operand
        + {7'h00, status[FLG_C]})))
        else $error("carry not added");
endmodule
`default_nettype wire

/* sim/tb_add_and_instruction_exec.sv */
// Self-checking bench for the add/and instruction executor
`timescale 1ns/1ns
`default_nettype none
module tb_add_and_instruction_exec;
    import exec_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_instr = 16'h0000;
    logic i_instr_valid = 1'b0;
    logic i_extended_en = 1'b0;
    logic [3:0] i_bank_select_register = 4'h0;
    logic [11:0] i_index_base = 12'h000;
    logic [7:0] i_rd_data = 8'h00;
    logic o_busy, o_rd_en, o_wr_en, o_illegal, o_done;
    logic o_negative_flag, o_overflow_flag, o_zero_flag, o_digit_carry_flag, o_carry_flag;
    logic [1:0] o_phase;
    logic [11:0] o_addr;
    logic [7:0] o_wr_data, o_acc, acc_m;
    logic [4:0] flags_seen, fl_m;
    int errors = 0;
    int checked = 0;

    add_and_instruction_exec uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_instr(i_instr),
        .i_instr_valid(i_instr_valid), .i_extended_en(i_extended_en),
        .i_bank_select_register(i_bank_select_register), .i_index_base(i_index_base),
        .i_rd_data(i_rd_data), .o_busy(o_busy), .o_phase(o_phase), .o_rd_en(o_rd_en),
        .o_addr(o_addr), .o_wr_en(o_wr_en), .o_wr_data(o_wr_data), .o_acc(o_acc),
        .o_negative_flag(o_negative_flag), .o_overflow_flag(o_overflow_flag),
        .o_zero_flag(o_zero_flag), .o_digit_carry_flag(o_digit_carry_flag),
        .o_carry_flag(o_carry_flag), .o_illegal(o_illegal), .o_done(o_done));

    always_comb begin
        flags_seen[FLG_C] = o_carry_flag;
        flags_seen[FLG_DC] = o_digit_carry_flag;
        flags_seen[FLG_Z] = o_zero_flag;
        flags_seen[FLG_OV] = o_overflow_flag;
        flags_seen[FLG_N] = o_negative_flag;
    end

    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // ------------------------------------------------------------
    // Reference arithmetic and access tasks
    // ------------------------------------------------------------
    function automatic logic [10:0] addf(input logic [7:0] x, input logic [7:0] y, input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = x + y + c;
        h = x[3:0] + y[3:0] + c;
        return {s[8], h[4], (x[7] == y[7]) && (s[7] != x[7]), s[7:0]};
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Operand data is held for the whole instruction, so its read timing never matters
    task automatic exec(input logic [15:0] ins, input logic [7:0] rd);
        logic [7:0] f;
        logic [7:0] r;
        logic regop;
        logic cin;
        logic [11:0] ea;
        f = ins[7:0];
        regop = (ins[15:10] == OP_ADD_ACC_TO_REG) || (ins[15:10] == OP_ADD_WITH_CARRY);
        cin = (ins[15:10] == OP_ADD_WITH_CARRY) && fl_m[FLG_C];
        if (ins[BANK_BIT]) ea = {i_bank_select_register, f};
        else if (i_extended_en && f <= INDEX_LIMIT) ea = i_index_base + {4'h0, f};
        else ea = (f >= ACCESS_SPLIT) ? {ACCESS_HI_BANK, f} : {4'h0, f};
        if (ins[15:8] == OP_AND_LITERAL) r = acc_m & f;
        else {fl_m[FLG_C], fl_m[FLG_DC], fl_m[FLG_OV], r} = addf(acc_m, regop ? rd : f, cin);
        fl_m[FLG_N] = r[7];
        fl_m[FLG_Z] = (r == 8'h00);
        if (!(regop && ins[DEST_BIT])) acc_m = r;
        @(negedge i_ref_clk);
        i_instr = ins;
        i_instr_valid = 1'b1;
        i_rd_data = rd;
        @(negedge i_ref_clk);
        i_instr_valid = 1'b0;
        chk("phase", 16'h1, 16'(o_phase));
        chk("rd_en", 16'(regop), 16'(o_rd_en));
        if (regop) chk("addr", 16'(ea), 16'(o_addr));
        @(negedge i_ref_clk);
        // Offer a second request while busy; it must be ignored
        i_instr = {OP_AND_LITERAL, 8'h00};
        i_instr_valid = 1'b1;
        @(negedge i_ref_clk);
        i_instr_valid = 1'b0;
        chk("wr_en", 16'(regop & ins[DEST_BIT]), 16'(o_wr_en));
        if (regop & ins[DEST_BIT]) chk("wr_data", 16'(r), 16'(o_wr_data));
        @(negedge i_ref_clk);
        chk("done", 16'h1, 16'(o_done));
        chk("acc", 16'(acc_m), 16'(o_acc));
        chk("flags", 16'(fl_m), 16'(flags_seen));
    endtask

    // ------------------------------------------------------------
    // Test sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        acc_m = ACC_RESET;
        fl_m = STATUS_RESET;
        repeat (2) @(negedge i_ref_clk);
        i_rst = 1'b0;
        chk("acc_rst", 16'(ACC_RESET), 16'(o_acc));
        chk("flags_rst", 16'(STATUS_RESET), 16'(flags_seen));
        exec({OP_ADD_LITERAL, 8'h10}, 8'h00);
        exec({OP_ADD_LITERAL, 8'h15}, 8'h00);
        exec({OP_ADD_LITERAL, 8'h5B}, 8'h00);
        exec({OP_ADD_LITERAL, 8'h80}, 8'h00);
        exec({OP_AND_LITERAL, 8'hFF}, 8'h00);
        exec({OP_ADD_LITERAL, 8'hC2}, 8'h00);
        exec({OP_ADD_LITERAL, 8'hF0}, 8'h00);
        exec({OP_AND_LITERAL, 8'h85}, 8'h00);
        exec({OP_ADD_ACC_TO_REG, 2'b00, 8'h20}, 8'h17);
        exec({OP_ADD_ACC_TO_REG, 2'b00, 8'h80}, 8'h01);
        i_bank_select_register = 4'h3;
        exec({OP_ADD_ACC_TO_REG, 2'b11, 8'h40}, 8'hC2);
        i_extended_en = 1'b1;
        i_index_base = 12'h100;
        exec({OP_ADD_ACC_TO_REG, 2'b00, 8'h5F}, 8'h02);
        exec({OP_ADD_ACC_TO_REG, 2'b00, 8'h60}, 8'h03);
        exec({OP_ADD_LITERAL, 8'hFF}, 8'h00);
        exec({OP_ADD_WITH_CARRY, 2'b01, 8'h10}, 8'h4D);
        exec({OP_ADD_WITH_CARRY, 2'b10, 8'h30}, 8'h7E);
        @(negedge i_ref_clk);
        i_instr = 16'hFFFF;
        i_instr_valid = 1'b1;
        @(negedge i_ref_clk);
        i_instr_valid = 1'b0;
        chk("illegal", 16'h1, 16'(o_illegal));
        chk("busy", 16'h0, 16'(o_busy));
        chk("acc", 16'(acc_m), 16'(o_acc));
        end_of_test;
    end

    // Whole sequence needs about 85 cycles; 2000 leaves ample margin
    initial begin
        #40000;
        errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
